// ==== design/rcc_defs.svh ====
// register offsets, field positions, codes and widths of the receive-clear block
// included by every design file that needs a number; definitions only
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH

`define RCC_ADDR_W     4
`define RCC_DATA_W     32
`define RCC_CODE_W     16
`define RCC_NCH        2

// register offsets (byte addresses, one word each)
`define RCC_OFF_CMD    4'h0
`define RCC_OFF_STAT1  4'h4
`define RCC_OFF_STAT2  4'h8
`define RCC_OFF_ERR    4'hc

// command word fields
`define RCC_CH_LSB     0
`define RCC_REQ_LSB    8
`define RCC_EXEC_LSB   16
`define RCC_REQ_CLEAR  8'h04
`define RCC_EXEC_TYPE  8'h00

// error register fields
`define RCC_ERR_FLAG_BIT  16
`define RCC_ERR_MOD_BIT   17
`define RCC_ERR_CPU_BIT   18

// completion codes
`define RCC_ST_NORMAL  16'h0000
`define RCC_ERR_SIMUL  16'h7ff0
`define RCC_ERR_PROTO  16'h7ff2
`define RCC_CPU_LIMIT  16'h4fff
`define RCC_MOD_START  16'h7000

`endif

// ==== design/rcc_pkg.sv ====
// types shared by the receive-clear block
// assumes rcc_defs.svh is reachable on the include path
package rcc_pkg;

	typedef enum logic [3:0] {
		RCC_IDLE = 4'b0001,
		RCC_HOLD = 4'b0010,
		RCC_FIN  = 4'b0100,
		RCC_SHOW = 4'b1000
	} rcc_state_e;

	typedef enum logic [3:0] {
		RCC_K_NONE     = 4'h0,
		RCC_K_ON_DEMAND_SEND_COMMAND = 4'h1,
		RCC_K_SEND     = 4'h2,
		RCC_K_REGMSG   = 4'h3,
		RCC_K_BID_SEND = 4'h4,
		RCC_K_BID_RECV = 4'h5,
		RCC_K_REINIT   = 4'h6,
		RCC_K_RXREAD   = 4'h7,
		RCC_K_UF_WRITE = 4'h8,
		RCC_K_UF_READ  = 4'h9,
		RCC_K_INT_RECV = 4'ha,
		RCC_K_STATUS   = 4'hb
	} rcc_kind_e;

	typedef logic [15:0] rcc_code_t;

endpackage

// ==== design/rcc_rst_sync.sv ====
// reset release synchroniser: asserts at once, releases after two clock edges
// assumes an active low asynchronous reset input
`timescale 1ns/1ps
module rcc_rst_sync
	import rcc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_in_n,
	output logic      rst_out_n
);
	typedef struct packed {
		logic [1:0] ff;
	} rcc_sync_s;

	rcc_sync_s q, d;

	always_comb
	begin
		d = q;
		d.ff = {q.ff[0], 1'b1};
	end

	always_ff @(posedge clk or negedge rst_in_n)
	begin
		if (!rst_in_n)
			q <= '0;
		else
			q <= d;
	end

	assign rst_out_n = q.ff[1];
endmodule

// ==== design/rcc_chan.sv ====
// one channel of the receive-clear sequencer: wait, flush, report at scan end
// assumes one-cycle start and scan_end pulses and a synchronous reset copy
`timescale 1ns/1ps
`include "rcc_defs.svh"
module rcc_chan
	import rcc_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic         proto_predef,
	input  wire logic         busy_conflict,
	input  wire logic         rx_hold,
	input  wire logic         scan_end,
	output rcc_pkg::rcc_state_e state,
	output logic              active,
	output logic              flush,
	output logic              complete,
	output logic              abnormal,
	output logic              err_evt,
	output rcc_pkg::rcc_code_t code,
	output rcc_pkg::rcc_code_t status
);
	typedef struct packed {
		rcc_state_e st;
		logic       active;
		logic       flush;
		logic       complete;
		logic       abnormal;
		logic       err_evt;
		rcc_code_t  code;
		rcc_code_t  status;
	} rcc_chan_s;

	rcc_chan_s q, d;

	always_comb
	begin
		d = q;
		d.flush = 1'b0;
		d.err_evt = 1'b0;
		unique case (q.st)
			RCC_IDLE:
				if (start)
				begin
					d.active = 1'b1;
					if (proto_predef)
					begin
						d.code = `RCC_ERR_PROTO;
						d.st = RCC_FIN;
					end
					else if (busy_conflict)
					begin
						d.code = `RCC_ERR_SIMUL;
						d.st = RCC_FIN;
					end
					else
						d.st = RCC_HOLD;
				end
			RCC_HOLD:
				// receive signals still up: keep waiting
				if (!rx_hold)
				begin
					d.flush = 1'b1;
					d.code = `RCC_ST_NORMAL;
					d.st = RCC_FIN;
				end
			RCC_FIN:
				if (scan_end)
				begin
					d.complete = 1'b1;
					d.abnormal = (q.code != `RCC_ST_NORMAL);
					d.err_evt = (q.code != `RCC_ST_NORMAL);
					d.status = q.code;
					d.st = RCC_SHOW;
				end
			RCC_SHOW:
				if (scan_end)
				begin
					d.complete = 1'b0;
					d.abnormal = 1'b0;
					d.active = 1'b0;
					d.st = RCC_IDLE;
				end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.st <= RCC_IDLE;
		end
		else
			q <= d;
	end

	assign state = q.st;
	assign active = q.active;
	assign flush = q.flush;
	assign complete = q.complete;
	assign abnormal = q.abnormal;
	assign err_evt = q.err_evt;
	assign code = q.code;
	assign status = q.status;
endmodule

// ==== design/rcc_top.sv ====
// receive-data clear command handler for a two-channel serial module
// assumes a host that writes commands over the plain register port and pulses
// SCAN_END once per scan at its end processing; all inputs but the asynchronous RESET_N synchronous to SYS_CLK
//
// Behaviour
// - clear discards received data in operating area
// - user reception area in buffer memory untouched
// - wait while read request or error detect
// - overlapping send-type or reinit fails later one
// - conflict checks apply to same channel only
// - clear during active receive read fails
// - receive read during active clear runs
// - second clear ignored until first completes
// - clear on predefined-protocol channel fails
// - completion bit set at end, cleared next
// - abnormal bit stays off on normal completion
// - abnormal bit pulses with completion on error
// - error sets host flag and code word
// - code ranges split host and module errors
// - completion status word zero or error code
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "rcc_defs.svh"
module rcc_top
	import rcc_pkg::*;
(
	input  wire logic                         SYS_CLK,
	input  wire logic                         RESET_N,
	input  wire logic [`RCC_ADDR_W-1:0]       ADDR,
	input  wire logic [`RCC_DATA_W-1:0]       WDATA,
	input  wire logic                         WR,
	input  wire logic                         RD,
	output logic      [`RCC_DATA_W-1:0]       RDATA,
	input  wire logic                         SCAN_END,
	input  wire logic [`RCC_NCH-1:0]          RX_READ_REQ,
	input  wire logic [`RCC_NCH-1:0]          RX_ERR_DET,
	input  wire logic [`RCC_NCH-1:0]          PROTO_PREDEF,
	input  wire logic [`RCC_NCH-1:0]          SEND_BUSY,
	input  wire logic [`RCC_NCH-1:0]          RECV_READ_BUSY,
	input  wire logic                         CMD_START,
	input  rcc_pkg::rcc_kind_e                CMD_KIND,
	input  wire logic                         CMD_CH,
	output logic                              CMD_REJECT,
	output rcc_pkg::rcc_code_t                CMD_REJECT_CODE,
	output logic      [`RCC_NCH-1:0]          RX_FLUSH,
	output logic      [`RCC_NCH-1:0]          CLEAR_ACTIVE,
	output logic      [`RCC_NCH-1:0]          COMPLETE,
	output logic      [`RCC_NCH-1:0]          ABNORMAL,
	output logic                              HOST_ERROR_FLAG,
	output rcc_pkg::rcc_code_t                HOST_ERROR_CODE_WORD
);

	////////////////////////////////////////////////////////////////////////////
	// decoding helpers

	// kinds that may not overlap a clear on the same channel
	function automatic logic kind_conflicts(input rcc_kind_e k);
		unique case (k)
			RCC_K_ON_DEMAND_SEND_COMMAND, RCC_K_SEND, RCC_K_REGMSG,
			RCC_K_BID_SEND, RCC_K_BID_RECV, RCC_K_REINIT:
				kind_conflicts = 1'b1;
			default:
				kind_conflicts = 1'b0;
		endcase
	endfunction

	// a well formed clear command aimed at channel index ch
	function automatic logic clear_issue(input logic wr, input logic [`RCC_ADDR_W-1:0] a,
		input logic [`RCC_DATA_W-1:0] w, input int ch);
		clear_issue = wr && (a == `RCC_OFF_CMD)
			&& (w[`RCC_CH_LSB +: 8] == 8'(ch + 1))
			&& (w[`RCC_REQ_LSB +: 8] == `RCC_REQ_CLEAR)
			&& (w[`RCC_EXEC_LSB +: 8] == `RCC_EXEC_TYPE);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_n;

	rcc_rst_sync u_rst (
		.clk       (SYS_CLK),
		.rst_in_n  (RESET_N),
		.rst_out_n (rst_n)
	);

	////////////////////////////////////////////////////////////////////////////
	// per-channel sequencers

	logic       [`RCC_NCH-1:0] issue;
	logic       [`RCC_NCH-1:0] ch_err_evt;
	rcc_state_e                ch_state [`RCC_NCH];
	rcc_code_t                 ch_code  [`RCC_NCH];
	rcc_code_t                 ch_stat  [`RCC_NCH];

	generate
		for (genvar g = 0; g < `RCC_NCH; g++)
		begin : g_ch
			assign issue[g] = clear_issue(WR, ADDR, WDATA, g);

			// only this channel's busy lines reach its sequencer
			rcc_chan u_chan (
				.clk           (SYS_CLK),
				.rst_n         (rst_n),
				.start         (issue[g]),
				.proto_predef  (PROTO_PREDEF[g]),
				.busy_conflict (SEND_BUSY[g] | RECV_READ_BUSY[g]),
				.rx_hold       (RX_READ_REQ[g] | RX_ERR_DET[g]),
				.scan_end      (SCAN_END),
				.state         (ch_state[g]),
				.active        (CLEAR_ACTIVE[g]),
				.flush         (RX_FLUSH[g]),
				.complete      (COMPLETE[g]),
				.abnormal      (ABNORMAL[g]),
				.err_evt       (ch_err_evt[g]),
				.code          (ch_code[g]),
				.status        (ch_stat[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// host error flag, rejection of later commands, read port

	typedef struct packed {
		logic [`RCC_DATA_W-1:0] rdata;
		logic                   err_flag;
		rcc_code_t              err_code;
		logic                   reject;
		rcc_code_t              reject_code;
	} rcc_top_s;

	rcc_top_s q, d;
	logic     clr_flag;
	logic     ch_hit;

	assign clr_flag = WR && (ADDR == `RCC_OFF_ERR) && WDATA[`RCC_ERR_FLAG_BIT];
	assign ch_hit = CLEAR_ACTIVE[CMD_CH];

	always_comb
	begin
		d = q;
		d.reject = 1'b0;
		// later conflicting command loses against an active clear
		if (CMD_START && kind_conflicts(CMD_KIND) && ch_hit)
		begin
			d.reject = 1'b1;
			d.reject_code = `RCC_ERR_SIMUL;
		end
		// set beats clear so no error completion is lost
		if (clr_flag)
			d.err_flag = 1'b0;
		if (ch_err_evt[0])
		begin
			d.err_flag = 1'b1;
			d.err_code = ch_code[0];
		end
		else if (ch_err_evt[1])
		begin
			d.err_flag = 1'b1;
			d.err_code = ch_code[1];
		end
		d.rdata = '0;
		if (RD)
		begin
			unique case (ADDR)
				`RCC_OFF_CMD:
					d.rdata[7:0] = {2'b00, ABNORMAL, COMPLETE, CLEAR_ACTIVE};
				`RCC_OFF_STAT1:
					d.rdata[15:0] = ch_stat[0];
				`RCC_OFF_STAT2:
					d.rdata[15:0] = ch_stat[1];
				`RCC_OFF_ERR:
				begin
					d.rdata[15:0] = q.err_code;
					d.rdata[`RCC_ERR_FLAG_BIT] = q.err_flag;
					d.rdata[`RCC_ERR_MOD_BIT] = (q.err_code >= `RCC_MOD_START);
					d.rdata[`RCC_ERR_CPU_BIT] = q.err_flag && (q.err_code <= `RCC_CPU_LIMIT);
				end
				default:
					d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign RDATA = q.rdata;
	assign HOST_ERROR_FLAG = q.err_flag;
	assign HOST_ERROR_CODE_WORD = q.err_code;
	assign CMD_REJECT = q.reject;
	assign CMD_REJECT_CODE = q.reject_code;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!rst_n);

	generate
		for (genvar c = 0; c < `RCC_NCH; c++)
		begin : g_chk
			logic hold;
			logic idle_issue;
			assign hold = RX_READ_REQ[c] | RX_ERR_DET[c];
			assign idle_issue = issue[c] && (ch_state[c] == RCC_IDLE);

			sequence s_clean_issue;
				idle_issue && !PROTO_PREDEF[c] && !SEND_BUSY[c] && !RECV_READ_BUSY[c]
					##1 !hold;
			endsequence

			sequence s_end_pair;
				SCAN_END && ch_state[c] == RCC_FIN ##1 COMPLETE[c];
			endsequence

			property p_flush_after_issue;
				s_clean_issue |=> RX_FLUSH[c];
			endproperty
			a_flush_after_issue: assert property (p_flush_after_issue)
				else $error("clear did not flush operating area");

			property p_hold_blocks;
				ch_state[c] == RCC_HOLD && hold |=> !RX_FLUSH[c] && ch_state[c] == RCC_HOLD;
			endproperty
			a_hold_blocks: assert property (p_hold_blocks)
				else $error("clear ran while receive signals were up");

			property p_busy_fails;
				idle_issue && !PROTO_PREDEF[c] && (SEND_BUSY[c] || RECV_READ_BUSY[c])
					|=> ch_code[c] == `RCC_ERR_SIMUL && !RX_FLUSH[c] [*2];
			endproperty
			a_busy_fails: assert property (p_busy_fails)
				else $error("clear against busy command not failed");

			property p_proto_fails;
				idle_issue && PROTO_PREDEF[c] |=> ch_code[c] == `RCC_ERR_PROTO;
			endproperty
			a_proto_fails: assert property (p_proto_fails)
				else $error("clear on protocol channel not failed");

			property p_reject_later;
				CMD_START && kind_conflicts(CMD_KIND) && CMD_CH == c && CLEAR_ACTIVE[c]
					|=> CMD_REJECT && CMD_REJECT_CODE == `RCC_ERR_SIMUL;
			endproperty
			a_reject_later: assert property (p_reject_later)
				else $error("later conflicting command not rejected");

			// a repeat clear in a busy state that is not advancing this cycle must leave the running one alone
			property p_second_ignored;
				issue[c] && (ch_state[c] == RCC_HOLD && hold
					|| (ch_state[c] == RCC_FIN || ch_state[c] == RCC_SHOW) && !SCAN_END)
					|=> $stable(ch_code[c]) && $stable(ch_state[c]);
			endproperty
			a_second_ignored: assert property (p_second_ignored)
				else $error("second clear disturbed active one");

			property p_complete_one_scan;
				COMPLETE[c] && !SCAN_END |=> COMPLETE[c];
			endproperty
			a_complete_one_scan: assert property (p_complete_one_scan)
				else $error("completion bit dropped early");

			property p_complete_from_end;
				s_end_pair |-> $rose(COMPLETE[c]) && $past(SCAN_END);
			endproperty
			a_complete_from_end: assert property (p_complete_from_end)
				else $error("completion bit not raised at scan end");

			property p_flush_single;
				RX_FLUSH[c] |=> !RX_FLUSH[c];
			endproperty
			a_flush_single: assert property (p_flush_single)
				else $error("flush pulse longer than one cycle");

			// the busy level only ever starts from an accepted issue
			property p_start_only_idle;
				$rose(CLEAR_ACTIVE[c]) |-> $past(issue[c]) && $past(ch_state[c]) == RCC_IDLE;
			endproperty
			a_start_only_idle: assert property (p_start_only_idle)
				else $error("clear became active without a fresh issue");

			property p_complete_off;
				COMPLETE[c] && SCAN_END |=> !COMPLETE[c] && !ABNORMAL[c];
			endproperty
			a_complete_off: assert property (p_complete_off)
				else $error("completion bits not cleared at next end");

			property p_normal_quiet;
				COMPLETE[c] && ch_stat[c] == `RCC_ST_NORMAL |-> !ABNORMAL[c];
			endproperty
			a_normal_quiet: assert property (p_normal_quiet)
				else $error("abnormal bit on normal completion");

			property p_abnormal_pair;
				ABNORMAL[c] |-> COMPLETE[c] && ch_stat[c] != `RCC_ST_NORMAL;
			endproperty
			a_abnormal_pair: assert property (p_abnormal_pair)
				else $error("abnormal bit without error completion");
		end
	endgenerate

	property p_err_flag;
		ch_err_evt[0] |=> HOST_ERROR_FLAG && HOST_ERROR_CODE_WORD == $past(ch_code[0]);
	endproperty
	a_err_flag: assert property (p_err_flag)
		else $error("host error flag or code not written");

	property p_err_flag_second;
		ch_err_evt[1] && !ch_err_evt[0] |=> HOST_ERROR_FLAG && HOST_ERROR_CODE_WORD == $past(ch_code[1]);
	endproperty
	a_err_flag_second: assert property (p_err_flag_second)
		else $error("host error flag or code not written for second channel");

	property p_allowed_kinds;
		CMD_START && !kind_conflicts(CMD_KIND) |=> !CMD_REJECT;
	endproperty
	a_allowed_kinds: assert property (p_allowed_kinds)
		else $error("compatible command was rejected");

	property p_other_channel;
		CMD_START && !CLEAR_ACTIVE[CMD_CH] |=> !CMD_REJECT;
	endproperty
	a_other_channel: assert property (p_other_channel)
		else $error("command on free channel was rejected");

	property p_status_word;
		$rose(COMPLETE[0]) |-> ch_stat[0] == $past(ch_code[0]);
	endproperty
	a_status_word: assert property (p_status_word)
		else $error("completion status word wrong");

	property p_status_word_second;
		$rose(COMPLETE[1]) |-> ch_stat[1] == $past(ch_code[1]);
	endproperty
	a_status_word_second: assert property (p_status_word_second)
		else $error("second channel completion status word wrong");

endmodule

// ==== verif/rcc_host_model.sv ====
// host side model: marks the end processing of every scan with a one-cycle pulse
// assumes the block's clock and the raw, unsynchronised reset level of the bench
`timescale 1ns/1ps
module rcc_host_model
#(
	parameter int SCAN_LEN = 16
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      scan_end
);
	int cnt;
	// scans close regardless of command traffic, as on a running host
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			scan_end <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == SCAN_LEN - 1) ? 0 : cnt + 1;
			scan_end <= (cnt == SCAN_LEN - 1);
		end
	end
endmodule

// ==== verif/test_receive_data_clear_command.sv ====
// self-checking bench of the receive-clear block with a scan-end host model
// assumes the design files and rcc_pkg are compiled before this file
`timescale 1ns/1ps
module test_receive_data_clear_command;
	import rcc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        cmd_start = 1'b0;
	logic        cmd_ch = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [1:0]  rx_req = 2'h0;
	logic [1:0]  rx_err = 2'h0;
	logic [1:0]  predef = 2'h0;
	logic [1:0]  send_busy = 2'h0;
	logic [1:0]  rr_busy = 2'h0;
	logic [1:0]  flush, active, comp, abn;
	rcc_kind_e   kind = RCC_K_NONE;
	logic        rej, herr, scan_end;
	rcc_code_t   rej_code, hcode;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          nflush [2] = '{0, 0};

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
	begin
		if (flush[0] === 1'b1) nflush[0]++;
		if (flush[1] === 1'b1) nflush[1]++;
	end

	rcc_host_model #(.SCAN_LEN(16)) host (.clk(sys_clk), .rst_n(reset_n), .scan_end(scan_end));

	rcc_top DUT (.SYS_CLK(sys_clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .SCAN_END(scan_end), .RX_READ_REQ(rx_req), .RX_ERR_DET(rx_err),
		.PROTO_PREDEF(predef), .SEND_BUSY(send_busy), .RECV_READ_BUSY(rr_busy),
		.CMD_START(cmd_start), .CMD_KIND(kind), .CMD_CH(cmd_ch), .CMD_REJECT(rej),
		.CMD_REJECT_CODE(rej_code), .RX_FLUSH(flush), .CLEAR_ACTIVE(active), .COMPLETE(comp),
		.ABNORMAL(abn), .HOST_ERROR_FLAG(herr), .HOST_ERROR_CODE_WORD(hcode));

	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	// read data live only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic wait_comp(input int c, input logic v);
		for (int i = 0; i < 200; i++)
		begin
			@(posedge sys_clk);
			#1;
			if (comp[c] === v) return;
		end
		n_mismatch++;
		$display("ERROR completion wait expected %h seen %h", v, comp[c]);
		end_sim();
	endtask

	task automatic issue(input int k, input logic c, input logic exp);
		@(posedge sys_clk);
		cmd_start <= 1'b1;
		kind <= rcc_kind_e'(k);
		cmd_ch <= c;
		@(posedge sys_clk);
		cmd_start <= 1'b0;
		#1;
		chk("reject", 32'(exp), 32'(rej));
		if (exp) chk("reject code", 32'h0000_7ff0, 32'(rej_code));
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] d;
		for (int k = 0; k < 5; k++)
		begin
			rd_reg((k == 4) ? 4'h2 : 4'(k * 4), d);
			chk("reset register", 32'h0000_0000, d);
		end
		chk("reset outputs", 32'h0000_0000, 32'({active, comp, abn, flush, herr}));
	endtask

	task automatic t_normal();
		logic [31:0] d;
		int base;
		base = nflush[0];
		// malformed command words must not start anything
		wr_reg(4'h0, 32'h0001_0401);
		wr_reg(4'h0, 32'h0000_0301);
		wr_reg(4'h0, 32'h0000_0403);
		@(posedge sys_clk);
		#1;
		chk("malformed ignored", 32'h0, 32'(active));
		wr_reg(4'h0, 32'h0000_0401);
		wait_comp(0, 1'b1);
		chk("flush count", 32'(base + 1), 32'(nflush[0]));
		chk("abnormal", 32'h0, 32'(abn[0]));
		chk("error flag", 32'h0, 32'(herr));
		wait_comp(0, 1'b0);
		chk("abnormal after", 32'h0, 32'(abn[0]));
		chk("active", 32'h0, 32'(active[0]));
		rd_reg(4'h4, d);
		chk("status ch1", 32'h0000_0000, d);
	endtask

	// channel two held by the receive signals while other commands arrive
	task automatic t_hold();
		int base;
		base = nflush[1];
		@(posedge sys_clk);
		rx_req[1] <= 1'b1;
		wr_reg(4'h0, 32'h0000_0402);
		repeat (40) @(posedge sys_clk);
		#1;
		chk("held flush", 32'(base), 32'(nflush[1]));
		chk("held active", 32'h1, 32'(active[1]));
		for (int k = 1; k < 12; k++)
		begin
			issue(k, 1'b1, k <= 6);
			issue(k, 1'b0, 1'b0);
		end
		wr_reg(4'h0, 32'h0000_0402);
		@(posedge sys_clk);
		rx_req[1] <= 1'b0;
		rx_err[1] <= 1'b1;
		repeat (20) @(posedge sys_clk);
		#1;
		chk("error held flush", 32'(base), 32'(nflush[1]));
		@(posedge sys_clk);
		rx_err[1] <= 1'b0;
		wait_comp(1, 1'b1);
		chk("released flush", 32'(base + 1), 32'(nflush[1]));
		wait_comp(1, 1'b0);
		repeat (48) @(posedge sys_clk);
		#1;
		chk("second clear dropped", 32'h0, 32'({active[1], comp[1]}));
		chk("flush total", 32'(base + 1), 32'(nflush[1]));
	endtask

	task automatic t_fail(input int c, input logic [1:0] sb, rb, pp, input logic [15:0] code);
		logic [31:0] d;
		int base;
		base = nflush[c];
		@(posedge sys_clk);
		send_busy <= sb;
		rr_busy <= rb;
		predef <= pp;
		wr_reg(4'h0, 32'h0000_0400 | 32'(c + 1));
		@(posedge sys_clk);
		{send_busy, rr_busy, predef} <= 6'h00;
		wait_comp(c, 1'b1);
		chk("abnormal", 32'h1, 32'(abn[c]));
		// host flag lands one cycle behind the completion bits
		@(posedge sys_clk);
		#1;
		chk("error flag", 32'h1, 32'(herr));
		chk("error code", 32'(code), 32'(hcode));
		chk("no flush", 32'(base), 32'(nflush[c]));
		wait_comp(c, 1'b0);
		chk("abnormal off", 32'h0, 32'(abn[c]));
		rd_reg((c == 1) ? 4'h8 : 4'h4, d);
		chk("status word", 32'(code), d);
		rd_reg(4'hc, d);
		chk("error register", {13'h0000, code <= 16'h4fff, code >= 16'h7000, 1'b1, code}, d);
		wr_reg(4'hc, 32'h0001_0000);
		@(posedge sys_clk);
		#1;
		chk("flag cleared", 32'h0, 32'(herr));
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_normal();
		t_hold();
		t_fail(0, 2'b00, 2'b01, 2'b00, 16'h7ff0);
		t_fail(1, 2'b10, 2'b00, 2'b00, 16'h7ff0);
		t_fail(1, 2'b00, 2'b00, 2'b10, 16'h7ff2);
		end_sim();
	end
endmodule
